// >>> core/cic_comb.sv
// cic comb stage: unit delay differentiator at decimated rate
// assumes strobe is a one-cycle pulse once per output period
`default_nettype none
module cic_comb
   import cic_pkg::*;
(
   // clock and reset
   input  wire logic     clock,
   input  wire logic     rst,
   // decimated stream
   input  wire logic     strobe,
   input  wire cic_acc_t din,
   output var  cic_acc_t dout
);
   cic_acc_t delay_reg;
   cic_acc_t dout_reg;
   wire cic_acc_t diff = cic_wrap_sub(din, delay_reg);

   // single delay register updated only on the decimated strobe
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         delay_reg <= CIC_ACC_ZERO;
         dout_reg  <= CIC_ACC_ZERO;
      end else if (strobe) begin
         delay_reg <= din;
         dout_reg  <= diff;
      end
   end

   assign dout = dout_reg;
endmodule // cic_comb
`default_nettype wire

// >>> core/cic_pkg.sv
// cic decimator package: widths, ratio, order, stage carriers
// assumes a single 100 MHz sample clock domain
`default_nettype none
package cic_pkg;
   localparam int unsigned CIC_RATIO      = 16;   // decimation_ratio
   localparam int unsigned CIC_ORDER      = 3;    // filter_order
   localparam int unsigned CIC_IN_W       = 2;    // signed input word, 1-bit stream maps to +1/-1
   localparam int unsigned CIC_GROWTH     = CIC_ORDER * $clog2(CIC_RATIO);
   localparam int unsigned CIC_ACC_W      = CIC_IN_W + CIC_GROWTH;
   localparam int unsigned CIC_CNT_W      = $clog2(CIC_RATIO);
   localparam int unsigned CIC_FILL_W     = $clog2(CIC_ORDER + 1);
   localparam logic [CIC_CNT_W-1:0]  CIC_CNT_LAST = CIC_CNT_W'(CIC_RATIO - 1);
   localparam logic [CIC_CNT_W-1:0]  CIC_CNT_ZERO = '0;
   localparam logic [CIC_FILL_W-1:0] CIC_FILL_DONE = CIC_FILL_W'(CIC_ORDER);
   localparam logic [CIC_ACC_W-1:0]  CIC_ACC_ZERO = '0;

   typedef logic signed [CIC_ACC_W-1:0] cic_acc_t;

   // one decimated output word with its strobe
   typedef struct packed {
      logic     valid;
      cic_acc_t data;
   } cic_out_t;

   // input sample with its qualifier
   typedef struct packed {
      logic                       valid;
      logic signed [CIC_IN_W-1:0] data;
   } cic_in_t;

   // wraparound add/subtract at accumulator width
   function automatic cic_acc_t cic_wrap_add(input cic_acc_t a, input cic_acc_t b);
      return cic_acc_t'(a + b);
   endfunction

   function automatic cic_acc_t cic_wrap_sub(input cic_acc_t a, input cic_acc_t b);
      return cic_acc_t'(a - b);
   endfunction

   // sign extension of the input word to accumulator width
   function automatic cic_acc_t cic_extend(input logic signed [CIC_IN_W-1:0] x);
      return cic_acc_t'(x);
   endfunction
endpackage
`default_nettype wire

// >>> core/cic_sinc_decimator.sv
// cic sinc decimator: order-N integrators, down-sampler, order-N combs
// assumes sample_valid marks each modulator sample, synchronous to clock
`default_nettype none
module cic_sinc_decimator
   import cic_pkg::*;
(
   // clock and reset
   input  wire logic     clock,
   input  wire logic     rst,
   // modulator sample stream
   input  wire logic     sample_valid,
   input  wire logic     sample_bit,
   input  wire logic     multibit_mode,
   input  wire logic signed [CIC_IN_W-1:0] sample_word,
   // decimated output
   output var  cic_out_t out_word
);
   import cic_pkg::*;

   // input selection: a 1-bit stream maps to +1/-1, signed word passes as is
   // zero never occurs on the 1-bit path, so the stream mean is the level
   // a multi-bit word is taken whole and sign extended like the bit value
   wire logic signed [CIC_IN_W-1:0] bit_value = sample_bit ? CIC_IN_W'(1) : {CIC_IN_W{1'b1}};
   wire logic signed [CIC_IN_W-1:0] in_value  = multibit_mode ? sample_word : bit_value;
   wire cic_in_t  in_s = '{valid: sample_valid, data: in_value};
   wire cic_acc_t in_ext = cic_extend(in_s.data);

   // accepted sample, named once for every process that waits on it
   wire logic take = in_s.valid;

   // integrator chain, full width to carry ratio^order growth without loss
   // wraparound is harmless here: the combs take differences, and any
   // difference that fits the width comes out right whatever the overflow
   cic_acc_t integ_reg  [CIC_ORDER];
   cic_acc_t integ_next [CIC_ORDER];

   // stage 0 adds the new sample, each later stage adds the registered
   // output of the stage before it
   // the extra register per stage only delays the response, its shape
   // and gain stay those of the plain cascade
   always_comb begin
      for (int i = 0; i < CIC_ORDER; i++) begin
         integ_next[i] = cic_wrap_add(integ_reg[i], (i == 0) ? in_ext : integ_reg[i-1 < 0 ? 0 : i-1]);
      end
   end

   // integrators advance on every accepted sample and hold on idle cycles
   // holding keeps the running sums aligned to samples, not to clock cycles
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < CIC_ORDER; i++) integ_reg[i] <= CIC_ACC_ZERO;
      end else if (take) begin
         for (int i = 0; i < CIC_ORDER; i++) integ_reg[i] <= integ_next[i];
      end
   end

   // decimation counter: counts accepted samples within one output period
   // it restarts only on reset, so periods stay locked to the first sample
   logic [CIC_CNT_W-1:0] cnt_reg;
   logic [CIC_CNT_W-1:0] cnt_next;
   wire logic period_end = take && (cnt_reg == CIC_CNT_LAST);

   // next count wraps at the period end, cut to the counter width
   assign cnt_next = period_end ? CIC_CNT_ZERO : CIC_CNT_W'(cnt_reg + 1'b1);

   always_ff @(posedge clock or posedge rst) begin
      if (rst)
         cnt_reg <= CIC_CNT_ZERO;
      else if (take)
         cnt_reg <= cnt_next;
   end

   // one-cycle strobe for the decimated rate, a cycle after the period end
   logic strobe_reg;

   always_ff @(posedge clock or posedge rst) begin
      if (rst)
         strobe_reg <= 1'b0;
      else
         strobe_reg <= period_end;
   end

   // down-sampler: one value of the last integrator per period
   // taken from the next value, which holds samples up to two before the one that ends the period
   // all other running values are simply never looked at
   cic_acc_t down_reg;

   always_ff @(posedge clock or posedge rst) begin
      if (rst)
         down_reg <= CIC_ACC_ZERO;
      else if (period_end)
         down_reg <= integ_next[CIC_ORDER-1];
   end

   // comb chain at decimated rate, after all integrators
   // each comb needs a single delay register, not ratio of them, because
   // it only ever sees one value per period
   cic_acc_t comb_io [CIC_ORDER+1];
   logic     comb_strobe [CIC_ORDER+1];
   assign comb_io[0]     = down_reg;
   assign comb_strobe[0] = strobe_reg;

   genvar g;
   generate
      for (g = 0; g < CIC_ORDER; g++) begin : g_comb
         cic_comb u_comb (
            .clock  (clock),
            .rst    (rst),
            .strobe (comb_strobe[g]),
            .din    (comb_io[g]),
            .dout   (comb_io[g+1])
         );
         // each comb registers once, so its strobe trails by a cycle
         always_ff @(posedge clock or posedge rst) begin
            if (rst) comb_strobe[g+1] <= 1'b0;
            else     comb_strobe[g+1] <= comb_strobe[g];
         end
      end
   endgenerate

   // fill tracker: count output periods until order periods have passed
   // order periods of samples are what every stage needs to hold only
   // real data; earlier words mix in the zeros left by reset
   logic [CIC_FILL_W-1:0] fill_reg;
   logic [CIC_FILL_W-1:0] fill_next;
   wire logic filled = (fill_reg == CIC_FILL_DONE);

   // plain step, cut to the tracker width; the enable below holds it at order
   assign fill_next = CIC_FILL_W'(fill_reg + 1'b1);

   always_ff @(posedge clock or posedge rst) begin
      if (rst)
         fill_reg <= '0;
      else if (period_end && !filled)
         fill_reg <= fill_next;
   end

   // fill state sampled on the decimated strobe, so it belongs to the
   // same period as the word now entering the combs
   logic filled_d;

   always_ff @(posedge clock or posedge rst) begin
      if (rst)
         filled_d <= 1'b0;
      else if (strobe_reg)
         filled_d <= filled;
   end

   // a word leaves only once the pipeline holds a filled period
   wire logic out_take = comb_strobe[CIC_ORDER] && filled_d;

   // output strobe: one cycle per decimated word
   logic valid_reg;

   always_ff @(posedge clock or posedge rst) begin
      if (rst)
         valid_reg <= 1'b0;
      else
         valid_reg <= out_take;
   end

   // output data: moves only together with the strobe, so a reader that
   // polls the word between strobes never sees an unfilled partial sum
   cic_acc_t data_reg;

   always_ff @(posedge clock or posedge rst) begin
      if (rst)
         data_reg <= CIC_ACC_ZERO;
      else if (out_take)
         data_reg <= comb_io[CIC_ORDER];
   end

   // the output word carries strobe and data together
   // limitation: the strobe is not held, a consumer must take it that cycle
   assign out_word = '{valid: valid_reg, data: data_reg};
endmodule // cic_sinc_decimator
`default_nettype wire

// >>> testbench/cic_mod_model.sv
// modulator model: first-order sigma-delta bit source
// assumes take marks each sample the decimator consumes
`default_nettype none
module cic_mod_model (
   // clock and reset
   input  wire logic              clock,
   input  wire logic              rst,
   // level in, bit out
   input  wire logic              take,
   input  wire logic signed [8:0] level,
   output logic                   bit_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic signed [15:0] integ_reg;
   // +/-128 overdrives the +/-127 feedback, so the bit locks to full scale
   always @(posedge clock or posedge rst)
      if (rst) integ_reg <= '0;
      else if (take) integ_reg <= integ_reg + level - (bit_out ? 16'sh007F : -16'sh007F);
   assign bit_out = ~integ_reg[15];
endmodule // cic_mod_model
`default_nettype wire

// >>> testbench/cic_sinc_decimator_properties.sv
// checker: output timing, fill and settled value of the decimator
// assumes samples are counted from reset release
`default_nettype none
module cic_chk
   import cic_pkg::*;
(
   // clock and reset
   input wire logic                   clock,
   input wire logic                   rst,
   // watched ports
   input wire logic                   sample_valid,
   input wire logic                   sample_bit,
   input wire logic                   multibit_mode,
   input wire logic signed [CIC_IN_W-1:0] sample_word,
   input wire cic_out_t               out_word
);
   localparam cic_acc_t CIC_UNIT_GAIN = cic_acc_t'(CIC_RATIO ** CIC_ORDER);
   logic [CIC_CNT_W-1:0]  cnt_reg;
   logic [CIC_FILL_W-1:0] per_reg;
   logic [5:0]            run_reg;
   logic signed [1:0]     last_reg;
   wire logic signed [1:0] cur_x = multibit_mode ? sample_word : (sample_bit ? 2'sb01 : 2'sb11);
   wire logic end_w = sample_valid && cnt_reg == CIC_CNT_LAST;
   wire logic full_w = per_reg >= CIC_FILL_W'(CIC_ORDER - 1);
   wire logic same_w = cur_x == last_reg;
   // ratio is a power of two, so the sample counter simply wraps
   always_ff @(posedge clock or posedge rst)
      if (rst) begin
         cnt_reg <= '0;
         per_reg <= '0;
         run_reg <= '0;
         last_reg <= '0;
      end else if (sample_valid) begin
         cnt_reg <= cnt_reg + 1'b1;
         per_reg <= (end_w && per_reg != CIC_FILL_DONE) ? per_reg + 1'b1 : per_reg;
         run_reg <= !same_w ? 6'h01 : (run_reg == 6'h3F ? run_reg : run_reg + 1'b1);
         last_reg <= cur_x;
      end
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   sequence fill_end_s; end_w && full_w; endsequence
   sequence early_end_s; end_w && !full_w; endsequence
   sequence quiet_s; !out_word.valid [*8] ##1 !out_word.valid [*7]; endsequence
   fill_valid_a: assert property (fill_end_s |-> ##1 !out_word.valid [*4] ##1 out_word.valid)
      else $error("output strobe late or early");
   early_quiet_a: assert property (early_end_s |-> ##5 !out_word.valid)
      else $error("output strobe before fill");
   valid_cause_a: assert property (out_word.valid |-> $past(end_w, 5) && per_reg == CIC_FILL_DONE)
      else $error("output strobe without period end");
   valid_gap_a: assert property (out_word.valid |=> quiet_s)
      else $error("outputs closer than one period");
   data_hold_a: assert property (!out_word.valid |-> $stable(out_word.data))
      else $error("output word moved without strobe");
   reset_zero_a: assert property (per_reg == '0 |-> out_word == '0)
      else $error("output not clear after reset");
   idle_quiet_a: assert property (!sample_valid [*6] |-> !out_word.valid)
      else $error("output strobe without samples");
   steady_a: assert property (end_w && run_reg >= 6'd55 && same_w |->
      ##5 out_word.data == cic_acc_t'($past(cur_x, 5)) * CIC_UNIT_GAIN) else $error("settled word wrong");
endmodule // cic_chk
bind cic_sinc_decimator cic_chk chk (.clock(clock), .rst(rst), .sample_valid(sample_valid),
   .sample_bit(sample_bit), .multibit_mode(multibit_mode), .sample_word(sample_word), .out_word(out_word));
`default_nettype wire

// >>> testbench/tb.sv
// testbench: random then constant streams through the decimator
// assumes the checker binds itself to the design
`default_nettype none
module tb;
   import cic_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0, rst = 1'b1, sample_valid = 1'b0, multibit_mode = 1'b0;
   logic signed [1:0] sample_word = '0;
   logic signed [8:0] level = '0;
   wire logic sample_bit;
   cic_out_t out_word;
   cic_acc_t last_data;
   int mismatches = 0, n_tests = 0, seed = 32'hca7352ce, nval = 0;
   always #5 clock = ~clock;
   cic_mod_model modl (.clock(clock), .rst(rst), .take(sample_valid), .level(level), .bit_out(sample_bit));
   cic_sinc_decimator uut (.clock(clock), .rst(rst), .sample_valid(sample_valid), .sample_bit(sample_bit),
      .multibit_mode(multibit_mode), .sample_word(sample_word), .out_word(out_word));
   // strobes counted mid-cycle, clear of the launching edge
   always @(negedge clock) if (out_word.valid === 1'b1) begin
      nval++;
      last_data = out_word.data;
   end
   task automatic cmp_word(input string what, input cic_acc_t exp, input cic_acc_t got);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("FAIL %s expected %0d seen %0d", what, exp, got);
      end
   endtask
   task automatic cmp_count(input string what, input int exp, input int got);
      n_tests++;
      if (got != exp) begin
         mismatches++;
         $display("FAIL %s expected %0d seen %0d", what, exp, got);
      end
   endtask
   function automatic cic_acc_t exp_word(input logic signed [1:0] x);
      return cic_acc_t'(x) * cic_acc_t'(CIC_RATIO ** CIC_ORDER);
   endfunction
   task automatic results();
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // reset, 32 random samples with gaps, then 64 constant; aligned to periods
   task automatic run_case(input logic mb, input logic signed [1:0] x);
      int n;
      rst = 1'b1;
      multibit_mode = mb;
      repeat (2) @(posedge clock);
      #1 rst = 1'b0;
      nval = 0;
      last_data = 'x;
      n = 0;
      while (n < 96) begin
         sample_valid = ($random(seed) & 3) != 0;
         if (sample_valid) n++;
         level = n <= 32 ? 9'($random(seed) % 128) : (x > 0 ? 9'sd128 : -9'sd128);
         sample_word = n <= 32 ? 2'($random(seed)) : x;
         @(posedge clock);
         #1;
      end
      sample_valid = 1'b0;
      repeat (8) @(posedge clock);
      #1;
      cmp_count("output count", 96 / CIC_RATIO - (CIC_ORDER - 1), nval);
      cmp_word("settled word", exp_word(x), last_data);
   endtask
   initial begin
      run_case(1'b0, 2'sb01);
      run_case(1'b0, 2'sb11);
      for (int i = -2; i < 2; i++) run_case(1'b1, 2'(i));
      results();
   end
   // watchdog, well past six cases of about 150 cycles
   initial begin
      #50000;
      mismatches++;
      results();
   end
endmodule // tb
`default_nettype wire
